// >>> rtl/bay_regs_pkg.sv
/*
 * Package of constants for the bay controller register set: word offsets,
 * field positions, reset values and bay count.
 * Assumes a 32-bit Avalon-MM register bus with byte addressing.
 */
package bay_regs_pkg;
    localparam int NUM_BAYS = 4;
    // global registers
    localparam logic [7:0] CAP_OFS = 8'h00;
    localparam logic [7:0] UID_OFS = 8'h04;
    // per-bay block: base + bay * stride
    localparam logic [7:0] BAY_BASE = 8'h10;
    localparam logic [7:0] BAY_STRIDE = 8'h10;
    localparam logic [3:0] MAP_SUB = 4'h0;
    localparam logic [3:0] STS_SUB = 4'h4;
    localparam logic [3:0] ENA_SUB = 4'h8;
    localparam logic [3:0] CTL_SUB = 4'hc;
    // capability register fields
    localparam int CAP_QTY_LSB = 0;
    localparam int CAP_LOCK_BIT = 8;
    localparam int CAP_BTN_BIT = 9;
    // port map fields
    localparam int MAP_PHY_LSB = 0;
    localparam int MAP_HOST_LSB = 8;
    // status word fields
    localparam int STS_FF_LSB = 0;
    localparam int STS_LOCK_BIT = 4;
    localparam int STS_IND_LSB = 5;
    localparam int STS_REMREQ_BIT = 7;
    localparam int STS_PCHG_BIT = 8;
    localparam int STS_PRES_BIT = 9;
    // event enable fields
    localparam int ENA_REMREQ_BIT = 0;
    localparam int ENA_PCHG_BIT = 1;
    // control fields
    localparam int CTL_IDPWR_BIT = 0;
    localparam int CTL_OPPWR_BIT = 1;
    localparam int CTL_HOLD_BIT = 2;
    localparam int CTL_IND_LSB = 4;
    // reset values: power off, interlock engaged
    localparam logic [31:0] CTL_RESET = 32'h0000_0004;
    localparam logic [31:0] ENA_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// >>> rtl/bay_sync.sv
/*
 * Two-flop synchroniser for a vector of pin levels.
 * Assumes inputs asynchronous to clock; output used only as a level.
 */
`timescale 1ns/1ps
module bay_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule

// >>> rtl/bay_controller.sv
/*
 * Bay controller register set: capability, per-bay port map, status,
 * event enable and control registers behind an Avalon-MM slave.
 * Assumes bay pins are asynchronous and pass bay_sync first; straps
 * (port indices, form factor, fitted features) are static wires.
 */
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
// What this block does
// - separate identification and operating power per bay
// - per-bay interlock holds device until released
// - report whether removal buttons are fitted
// - report lock fitted and each lock engaged
// - registers reflect device presence inputs
// - read-only lock support bit
// - read-only bay quantity field
// - read-only port indices and form factor
// - removal request status per bay, cleared by writing one
// - presence change sets sticky flag
// - writing one clears presence flag
`timescale 1ns/1ps
module bay_controller #(
    parameter int NUM_BAYS = bay_regs_pkg::NUM_BAYS,
    parameter logic [31:0] UNIQUE_ID = 32'h1234_5678 // arbitrary value
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // static straps
    input wire logic button_fitted,
    input wire logic [NUM_BAYS-1:0] lock_fitted,
    input wire logic [NUM_BAYS*8-1:0] phy_port_strap,
    input wire logic [NUM_BAYS*8-1:0] host_port_strap,
    input wire logic [NUM_BAYS*4-1:0] form_factor_strap,
    // bay pins
    input wire logic [NUM_BAYS-1:0] present_pin,
    input wire logic [NUM_BAYS-1:0] lock_pin,
    input wire logic [NUM_BAYS-1:0] remreq_pin,
    // bay drives and interrupt
    output logic [NUM_BAYS-1:0] identification_power,
    output logic [NUM_BAYS-1:0] operating_power,
    output logic [NUM_BAYS-1:0] interlock_hold,
    output logic [NUM_BAYS*2-1:0] bay_indicator_state,
    output logic irq
);
    logic [NUM_BAYS-1:0] present_s, lock_s, remreq_s;
    logic [NUM_BAYS-1:0] present_d_r, present_d_nxt;
    logic [NUM_BAYS-1:0] pchg_r, pchg_nxt;
    logic [NUM_BAYS-1:0] remreq_r, remreq_nxt;
    logic [NUM_BAYS-1:0] remreq_d_r, remreq_d_nxt;
    logic [1:0] ena_r [NUM_BAYS];
    logic [1:0] ena_nxt [NUM_BAYS];
    logic [5:0] ctl_r [NUM_BAYS];
    logic [5:0] ctl_nxt [NUM_BAYS];
    logic [31:0] readdata_nxt;
    logic waitrequest_nxt;
    logic irq_nxt;
    logic ack_r, ack_nxt;
    logic req;
    logic wr_take;
    logic bay_hit;
    logic [3:0] bay_idx;
    logic [3:0] sub_ofs;

    // pins cross into the clock domain before anything looks at them
    bay_sync #(.WIDTH(3*NUM_BAYS)) pin_sync (
        .clock(clock),
        .rst(rst),
        .d({present_pin, lock_pin, remreq_pin}),
        .q({present_s, lock_s, remreq_s})
    );

    // one wait cycle per access: a write is taken on the edge after the one where ack is set
    assign req = read | write;
    assign wr_take = write & ack_r;
    assign bay_idx = 4'(({24'h0, address} - {24'h0, bay_regs_pkg::BAY_BASE}) >> 4);
    assign sub_ofs = address[3:0];
    assign bay_hit = (address >= bay_regs_pkg::BAY_BASE) &&
        (32'(bay_idx) < NUM_BAYS);

    always_comb begin
        ack_nxt = req & ~ack_r;
        waitrequest_nxt = ~(req & ~ack_r);
        present_d_nxt = present_s;
        remreq_d_nxt = remreq_s;
        for (int b = 0; b < NUM_BAYS; b++) begin
            ena_nxt[b] = ena_r[b];
            ctl_nxt[b] = ctl_r[b];
            pchg_nxt[b] = pchg_r[b];
            remreq_nxt[b] = remreq_r[b];
            // clear first so a same-cycle event wins
            if (wr_take && bay_hit && 32'(bay_idx) == b) begin
                if (sub_ofs == bay_regs_pkg::STS_SUB && byteenable[1]) begin
                    if (writedata[bay_regs_pkg::STS_PCHG_BIT])
                        pchg_nxt[b] = 1'b0;
                    if (writedata[bay_regs_pkg::STS_REMREQ_BIT])
                        remreq_nxt[b] = 1'b0;
                end
                if (sub_ofs == bay_regs_pkg::ENA_SUB && byteenable[0])
                    ena_nxt[b] = writedata[1:0];
                if (sub_ofs == bay_regs_pkg::CTL_SUB && byteenable[0])
                    ctl_nxt[b] = writedata[5:0];
            end
            if (present_s[b] != present_d_r[b])
                pchg_nxt[b] = 1'b1;
            if (button_fitted && remreq_s[b] && !remreq_d_r[b])
                remreq_nxt[b] = 1'b1;
        end
        irq_nxt = 1'b0;
        for (int b = 0; b < NUM_BAYS; b++) begin
            if ((pchg_r[b] && ena_r[b][bay_regs_pkg::ENA_PCHG_BIT]) ||
                (remreq_r[b] && ena_r[b][bay_regs_pkg::ENA_REMREQ_BIT]))
                irq_nxt = 1'b1;
        end
    end

    // read mux
    always_comb begin
        readdata_nxt = bay_regs_pkg::UNMAPPED_DATA;
        if (read && !ack_r) begin
            if (address == bay_regs_pkg::CAP_OFS) begin
                readdata_nxt[bay_regs_pkg::CAP_QTY_LSB +: 8] = 8'(NUM_BAYS);
                readdata_nxt[bay_regs_pkg::CAP_LOCK_BIT] = |lock_fitted;
                readdata_nxt[bay_regs_pkg::CAP_BTN_BIT] = button_fitted;
            end else if (address == bay_regs_pkg::UID_OFS) begin
                readdata_nxt = UNIQUE_ID;
            end else if (bay_hit) begin
                for (int b = 0; b < NUM_BAYS; b++) begin
                    if (32'(bay_idx) == b) begin
                        unique case (sub_ofs)
                            bay_regs_pkg::MAP_SUB: begin
                                readdata_nxt[bay_regs_pkg::MAP_PHY_LSB +: 8] =
                                    phy_port_strap[b*8 +: 8];
                                readdata_nxt[bay_regs_pkg::MAP_HOST_LSB +: 8] =
                                    host_port_strap[b*8 +: 8];
                            end
                            bay_regs_pkg::STS_SUB: begin
                                readdata_nxt[bay_regs_pkg::STS_FF_LSB +: 4] =
                                    form_factor_strap[b*4 +: 4];
                                readdata_nxt[bay_regs_pkg::STS_LOCK_BIT] =
                                    lock_fitted[b] & lock_s[b];
                                readdata_nxt[bay_regs_pkg::STS_IND_LSB +: 2] =
                                    ctl_r[b][bay_regs_pkg::CTL_IND_LSB +: 2];
                                readdata_nxt[bay_regs_pkg::STS_REMREQ_BIT] =
                                    remreq_r[b];
                                readdata_nxt[bay_regs_pkg::STS_PCHG_BIT] = pchg_r[b];
                                readdata_nxt[bay_regs_pkg::STS_PRES_BIT] =
                                    present_s[b];
                            end
                            bay_regs_pkg::ENA_SUB: readdata_nxt[1:0] = ena_r[b];
                            bay_regs_pkg::CTL_SUB: readdata_nxt[5:0] = ctl_r[b];
                            default: readdata_nxt = bay_regs_pkg::UNMAPPED_DATA;
                        endcase
                    end
                end
            end
        end else if (read) begin
            readdata_nxt = readdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            waitrequest <= 1'b1;
            readdata <= '0;
            irq <= 1'b0;
            present_d_r <= '0;
            remreq_d_r <= '0;
            pchg_r <= '0;
            remreq_r <= '0;
            for (int b = 0; b < NUM_BAYS; b++) begin
                ena_r[b] <= bay_regs_pkg::ENA_RESET[1:0];
                ctl_r[b] <= bay_regs_pkg::CTL_RESET[5:0];
            end
        end else begin
            ack_r <= ack_nxt;
            waitrequest <= waitrequest_nxt;
            readdata <= readdata_nxt;
            irq <= irq_nxt;
            present_d_r <= present_d_nxt;
            remreq_d_r <= remreq_d_nxt;
            pchg_r <= pchg_nxt;
            remreq_r <= remreq_nxt;
            for (int b = 0; b < NUM_BAYS; b++) begin
                ena_r[b] <= ena_nxt[b];
                ctl_r[b] <= ctl_nxt[b];
            end
        end
    end

    // bay drives are their own flops loaded from ctl_nxt, so they track the control flops
    generate
        for (genvar g = 0; g < NUM_BAYS; g++) begin : g_drive
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    identification_power[g] <= 1'b0;
                    operating_power[g] <= 1'b0;
                    interlock_hold[g] <= 1'b1;
                    bay_indicator_state[g*2 +: 2] <= 2'b00;
                end else begin
                    identification_power[g] <= ctl_nxt[g][bay_regs_pkg::CTL_IDPWR_BIT];
                    operating_power[g] <= ctl_nxt[g][bay_regs_pkg::CTL_OPPWR_BIT];
                    interlock_hold[g] <= ctl_nxt[g][bay_regs_pkg::CTL_HOLD_BIT];
                    bay_indicator_state[g*2 +: 2] <= ctl_nxt[g][bay_regs_pkg::CTL_IND_LSB +: 2];
                end
            end
        end
    endgenerate

    pres_flag_a: assert property (@(posedge clock) disable iff (rst)
        (present_s[0] != present_d_r[0]) |=> pchg_r[0])
        else $error("presence change not flagged");
    pres_clear_a: assert property (@(posedge clock) disable iff (rst)
        (wr_take && address == 8'h14 && byteenable[1] && writedata[8] &&
         present_s[0] == present_d_r[0]) |=> !pchg_r[0])
        else $error("presence flag not cleared");
    irq_cause_a: assert property (@(posedge clock) disable iff (rst)
        (pchg_r[0] && ena_r[0][1]) |=> irq)
        else $error("interrupt missing");
    irq_none_a: assert property (@(posedge clock) disable iff (rst)
        (!(|(pchg_r & {NUM_BAYS{1'b1}})) && !(|remreq_r)) |=> !irq)
        else $error("spurious interrupt");
    power_follow_a: assert property (@(posedge clock) disable iff (rst)
        (wr_take && address == 8'h1c && byteenable[0]) |=>
        identification_power[0] == $past(writedata[0]) &&
        operating_power[0] == $past(writedata[1]))
        else $error("power rails not updated");
    hold_follow_a: assert property (@(posedge clock) disable iff (rst)
        (wr_take && address == 8'h1c && byteenable[0]) |=>
        interlock_hold[0] == $past(writedata[2]))
        else $error("interlock not updated");
    qty_read_a: assert property (@(posedge clock) disable iff (rst)
        (read && !ack_r && address == 8'h00) |=>
        readdata[7:0] == 8'(NUM_BAYS) && readdata[8] == $past(|lock_fitted) &&
        readdata[9] == $past(button_fitted))
        else $error("capability read wrong");
    pres_read_a: assert property (@(posedge clock) disable iff (rst)
        (read && !ack_r && address == 8'h14) |=> readdata[9] == $past(present_s[0]))
        else $error("presence read wrong");
    remreq_set_a: assert property (@(posedge clock) disable iff (rst)
        (button_fitted && remreq_s[0] && !remreq_d_r[0]) |=> remreq_r[0])
        else $error("removal request lost");
    bus_ack_a: assert property (@(posedge clock) disable iff (rst)
        (req && waitrequest) |=> !waitrequest)
        else $error("bus did not answer");
    // a second answer in a row would let the master's next request be taken unseen
    wait_one_a: assert property (@(posedge clock) disable iff (rst)
        !waitrequest |=> waitrequest)
        else $error("answer held too long");
    ena_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr_take && address == 8'h18 && byteenable[0]) |=> ena_r[0] == $past(writedata[1:0]))
        else $error("enable not written");
    remreq_none_a: assert property (@(posedge clock) disable iff (rst)
        (!button_fitted && !remreq_r[0]) |=> !remreq_r[0])
        else $error("removal request without button");
    remreq_clear_a: assert property (@(posedge clock) disable iff (rst)
        (wr_take && address == 8'h44 && byteenable[1] && writedata[7] &&
         !(button_fitted && remreq_s[3] && !remreq_d_r[3])) |=> !remreq_r[3])
        else $error("removal request not cleared");
    flag_hold_a: assert property (@(posedge clock) disable iff (rst)
        (pchg_r[0] && !(wr_take && address == 8'h14 && byteenable[1] && writedata[8]))
        |=> pchg_r[0])
        else $error("presence flag lost");
    lock_read_a: assert property (@(posedge clock) disable iff (rst)
        (read && !ack_r && address == 8'h34) |=>
        readdata[4] == $past(lock_fitted[2] & lock_s[2]))
        else $error("lock state read wrong");
    map_read_a: assert property (@(posedge clock) disable iff (rst)
        (read && !ack_r && address == 8'h10) |=>
        readdata[15:0] == $past({host_port_strap[7:0], phy_port_strap[7:0]}))
        else $error("port map read wrong");
    unmapped_read_a: assert property (@(posedge clock) disable iff (rst)
        (read && !ack_r && address == 8'hf0) |=> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule

// >>> bench/tb_bay_controller.sv
/*
 * Self-checking bench for the bay controller register set.
 * Assumes the package offsets and field layout and a one-wait Avalon slave.
 */
`timescale 1ns/1ps
module tb_bay_controller;
    typedef struct {logic [7:0] addr; logic [31:0] exp;} row_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic [3:0] present_pin = 4'h0;
    logic [3:0] lock_pin = 4'h6;
    logic [3:0] remreq_pin = 4'h0;
    logic button_fitted = 1'b1;
    logic [3:0] identification_power;
    logic [3:0] operating_power;
    logic [3:0] interlock_hold;
    logic [7:0] bay_indicator_state;
    logic irq;
    logic [31:0] q;
    int n_fail = 0;
    int n_tests = 0;
    row_t rows[12];

    always #25 clock = ~clock;

    bay_controller dut (.clock(clock), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .button_fitted(button_fitted),
        .lock_fitted(4'h4), .phy_port_strap(32'h0403_0201),
        .host_port_strap(32'h1413_1211), .form_factor_strap(16'h4321),
        .present_pin(present_pin), .lock_pin(lock_pin), .remreq_pin(remreq_pin),
        .identification_power(identification_power), .operating_power(operating_power),
        .interlock_hold(interlock_hold), .bay_indicator_state(bay_indicator_state),
        .irq(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // holds the request until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= 4'hf;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) chk(1'b1, 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wrap_up;
        $display("counts: tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end

    initial begin
        // capability: quantity 4, a lock fitted, buttons fitted
        rows = '{'{8'h00, 32'h0000_0304}, '{8'h04, 32'h1234_5678},
            '{8'h10, 32'h0000_1101}, '{8'h20, 32'h0000_1202},
            '{8'h30, 32'h0000_1303}, '{8'h40, 32'h0000_1404},
            '{8'h14, 32'h0000_0001}, '{8'h24, 32'h0000_0002},
            '{8'h34, 32'h0000_0013}, '{8'h18, 32'h0000_0000},
            '{8'h1c, 32'h0000_0004}, '{8'hf0, 32'h0000_0000}};
        repeat (3) @(posedge clock);
        #1;
        chk({waitrequest, irq}, 2'b10);
        chk({identification_power, operating_power, interlock_hold}, 12'h00f);
        rst <= 1'b0;
        wait_cyc(4);
        $display("test reset done");
        foreach (rows[i]) rd(rows[i].addr, rows[i].exp);
        bus(1'b1, 8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h0000_0304);
        $display("test register table done");
        bus(1'b1, 8'h1c, 32'h0000_0001);
        wait_cyc(2);
        chk({identification_power, operating_power, interlock_hold}, 12'h10e);
        bus(1'b1, 8'h1c, 32'h0000_0027);
        wait_cyc(2);
        chk({identification_power, operating_power, interlock_hold}, 12'h11f);
        chk(bay_indicator_state, 8'h02);
        rd(8'h14, 32'h0000_0041);
        $display("test power and interlock done");
        present_pin <= 4'h2;
        wait_cyc(6);
        rd(8'h24, 32'h0000_0302);
        chk(irq, 1'b0);
        bus(1'b1, 8'h28, 32'h0000_0002);
        wait_cyc(3);
        chk(irq, 1'b1);
        bus(1'b1, 8'h24, 32'h0000_0000);
        rd(8'h24, 32'h0000_0302);
        bus(1'b1, 8'h24, 32'h0000_0100);
        rd(8'h24, 32'h0000_0202);
        wait_cyc(2);
        chk(irq, 1'b0);
        present_pin <= 4'h0;
        wait_cyc(6);
        rd(8'h24, 32'h0000_0102);
        chk(irq, 1'b1);
        $display("test presence change done");
        remreq_pin <= 4'h8;
        lock_pin <= 4'h2;
        wait_cyc(6);
        rd(8'h44, 32'h0000_0084);
        rd(8'h34, 32'h0000_0003);
        bus(1'b1, 8'h44, 32'h0000_0080);
        rd(8'h44, 32'h0000_0004);
        button_fitted <= 1'b0;
        remreq_pin <= 4'h0;
        wait_cyc(4);
        remreq_pin <= 4'h8;
        wait_cyc(6);
        rd(8'h00, 32'h0000_0104);
        rd(8'h44, 32'h0000_0004);
        $display("test removal and lock done");
        @(posedge clock);
        rst <= 1'b1;
        wait_cyc(2);
        chk({waitrequest, irq}, 2'b10);
        chk({identification_power, operating_power, interlock_hold}, 12'h00f);
        rst <= 1'b0;
        wait_cyc(3);
        rd(8'h28, 32'h0000_0000);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
